/* File: ewd_regs.svh */
// ewd_regs.svh: named constants of the spi eeprom watchdog command logic
// What this block does
// RULE1 - protect pin freezes lock and watchdog bits
// RULE2 - read opcode plus 16-bit address returns data
// RULE3 - read address steps after each byte
// RULE4 - read address wraps to zero past top
// RULE5 - chip select high stops output, ends read
// RULE6 - status read opcode shifts status byte out
// RULE7 - latch set needs its own eight-bit frame
// RULE8 - host sends write opcode, address, data
// RULE9 - write frame spans 32 clocks, select low
// RULE10 - write data wraps within its page
// RULE11 - latch, lock range and pin gate writes; the pin gates only status writes, not array writes
// RULE12 - write starts only if deselected on boundary
// RULE13 - status write byte has bits 0,1 zero
// RULE14 - busy flag reads one during write cycle
// RULE15 - watchdog timeout drives reset to active level
// RULE16 - reset pin is open drain
// RULE17 - power-up: output off, latch, flag cleared
// RULE18 - nothing accepted before first select fall
// RULE19 - reset held active for power-up interval
// RULE20 - decode the seven eight-bit opcodes
// RULE21 - status byte layout, latch and busy read-only
// RULE22 - watchdog periods, code three disables it
// RULE23 - lock codes guard none, quarter, half, all
// RULE24 - end of write clears busy and latch
`ifndef EWD_REGS_SVH
`define EWD_REGS_SVH

// ****************************************************************
// opcodes, msb first
// ****************************************************************
`define EWD_OP_SET_WRITE_LATCH_CMD_LATCH 8'h06
`define EWD_OP_FLAG_SET   8'h00
`define EWD_OP_CLEAR      8'h04
`define EWD_OP_STAT_RD    8'h05
`define EWD_OP_STAT_WR    8'h01
`define EWD_OP_READ       8'h03
`define EWD_OP_WRITE      8'h02

// ****************************************************************
// status byte fields
// ****************************************************************
`define EWD_SR_PPEN       7
`define EWD_SR_WD_HI      5
`define EWD_SR_WD_LO      4
`define EWD_SR_BL_HI      3
`define EWD_SR_BL_LO      2
`define EWD_WD_OFF        2'h3
`define EWD_WD_P0         2'h0
`define EWD_WD_P1         2'h1
`define EWD_BL_NONE       2'h0
`define EWD_BL_QUARTER    2'h1
`define EWD_BL_HALF       2'h2

// ****************************************************************
// array geometry and buffering
// ****************************************************************
`define EWD_ADDR_BITS     13
`define EWD_ADDR_MSB      12
`define EWD_PAGE_BITS     5
`define EWD_PAGE_LAST     5'h1f
`define EWD_MEM_WORDS     8192
`define EWD_PAGE_WORDS    32
`define EWD_FIFO_DEPTH    16
`define EWD_FIFO_WIDTH    8
`define EWD_BYTE_LAST     3'h7

// ****************************************************************
// times and the clock rate
// ****************************************************************
`define EWD_CLK_KHZ       20000
`define EWD_WDT_P0_MS     1400
`define EWD_WDT_P1_MS     600
`define EWD_WDT_P2_MS     200
`define EWD_PWRUP_MS      100
`define EWD_RST_PULSE_MS  100
`define EWD_WR_CYCLE_MS   5

`endif

/* File: ewd_pkg.sv */
// ewd_pkg.sv: types of the spi eeprom watchdog command logic
`include "ewd_regs.svh"
package ewd_pkg;

  // ****************************************************************
  // link and write-cycle states
  // ****************************************************************
  typedef enum logic [7:0] {
    L_IDLE   = 8'h01,
    L_OPC    = 8'h02,
    L_ADDR   = 8'h04,
    L_TXD    = 8'h08,
    L_RXD    = 8'h10,
    L_SDATA  = 8'h20,
    L_CMDEND = 8'h40,
    L_SKIP   = 8'h80
  } ewd_link_t;

  typedef enum logic [3:0] {
    C_IDLE  = 4'h1,
    C_DRAIN = 4'h2,
    C_PROG  = 4'h4,
    C_WAIT  = 4'h8
  } ewd_commit_t;

  // ****************************************************************
  // register state of the core, less the array, page buffer and fifo
  // ****************************************************************
  typedef struct packed {
    logic                         cs_s1;
    logic                         cs_s2;
    logic                         cs_d;
    logic                         sck_s1;
    logic                         sck_s2;
    logic                         sck_d;
    logic                         si_s1;
    logic                         si_s2;
    logic                         wp_s1;
    logic                         wp_s2;
    ewd_link_t                    link;
    logic [7:0]                   opcode;
    logic [7:0]                   shreg;
    logic [2:0]                   bitcnt;
    logic                         abyte;
    logic                         got_byte;
    logic [15:0]                  addr;
    logic [7:0]                   tx;
    logic                         so;
    logic                         so_oe;
    logic [7:0]                   sw_data;
    logic                         ppen;
    logic                         flag;
    logic [1:0]                   wd;
    logic [1:0]                   bl;
    logic                         write_enable_latch;
    ewd_commit_t                  cst;
    logic [`EWD_ADDR_MSB:`EWD_PAGE_BITS] pg_base;
    logic [`EWD_PAGE_BITS-1:0]    pg_ofs;
    logic [`EWD_PAGE_WORDS-1:0]   pg_mask;
    logic [`EWD_PAGE_BITS-1:0]    prog_idx;
    logic [31:0]                  timer;
    logic                         por_done;
    logic [31:0]                  por_cnt;
    logic [31:0]                  wdt_cnt;
    logic [31:0]                  rst_cnt;
    logic                         rst_oe;
  } ewd_state_t;

endpackage

/* File: ewd_fifo.sv */
// ewd_fifo.sv: valid/ready fifo carrying write data bytes
`timescale 1ns/100ps
module ewd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } ewd_fifo_state_t;

  ewd_fifo_state_t s;
  ewd_fifo_state_t next_s;
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic             push;
  logic             pop;

  // ****************************************************************
  // pointers and fill count
  // ****************************************************************
  // full and empty come from the count, so no slot is sacrificed
  always_comb begin
    next_s      = s;
    in_ready_o  = (s.cnt != (AW+1)'(DEPTH));
    out_valid_o = (s.cnt != '0);
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    if (push) begin
      next_s.wp = (s.wp == AW'(DEPTH-1)) ? '0 : s.wp + AW'(1);
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(DEPTH-1)) ? '0 : s.rp + AW'(1);
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // storage holds no reset; only counted slots are ever read
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      store[s.wp] <= in_data_i;
    end
  end

  assign out_data_o = store[s.rp];

endmodule // ewd_fifo

/* File: ewd_spi_eeprom_wdt.sv */
// ewd_spi_eeprom_wdt.sv: spi command, protection and watchdog logic of the memory
`timescale 1ns/100ps
`include "ewd_regs.svh"
module ewd_spi_eeprom_wdt #(
  parameter bit          ACTIVE_HIGH_RESET = 1'b0,
  parameter logic [31:0] WDT_P0_CYC        = `EWD_WDT_P0_MS * `EWD_CLK_KHZ,
  parameter logic [31:0] WDT_P1_CYC        = `EWD_WDT_P1_MS * `EWD_CLK_KHZ,
  parameter logic [31:0] WDT_P2_CYC        = `EWD_WDT_P2_MS * `EWD_CLK_KHZ,
  parameter logic [31:0] PWRUP_CYC         = `EWD_PWRUP_MS * `EWD_CLK_KHZ,
  parameter logic [31:0] RST_PULSE_CYC     = `EWD_RST_PULSE_MS * `EWD_CLK_KHZ,
  parameter logic [31:0] WR_CYCLE_CYC      = `EWD_WR_CYCLE_MS * `EWD_CLK_KHZ
) (
  input  wire logic  sys_clk_i,
  input  wire logic  reset_i,
  input  wire logic  cs_n_i,
  input  wire logic  sck_i,
  input  wire logic  si_i,
  input  wire logic  wp_n_i,
  output logic       so_o,
  output logic       so_oe_o,
  output logic       wdt_rst_o,
  output logic       wdt_rst_oe_o,
  output logic [7:0] status_o
);
  // reset picture: link idle, serial output released, reset pin asserted, latch and flag clear
  localparam ewd_pkg::ewd_state_t RST_S = '{
    link:    ewd_pkg::L_IDLE,
    cst:     ewd_pkg::C_IDLE,
    rst_oe:  ~ACTIVE_HIGH_RESET,
    default: '0
  };

  ewd_pkg::ewd_state_t s;
  ewd_pkg::ewd_state_t next_s;

  logic [7:0]  mem [0:`EWD_MEM_WORDS-1];
  logic [7:0]  page_buf [0:`EWD_PAGE_WORDS-1];

  logic        cs_fall;
  logic        cs_rise;
  logic        sck_rise;
  logic        sck_fall;
  logic        busy;
  logic        sr_prot;
  logic        byte_end;
  logic        rst_act;
  logic [7:0]  shifted;
  logic [7:0]  status;
  logic [15:0] full_addr;
  logic [`EWD_ADDR_MSB:0] prog_addr;
  logic        mem_we;
  logic [`EWD_ADDR_MSB:0] mem_wa;
  logic [7:0]  mem_wd;
  logic        pg_we;
  logic [`EWD_PAGE_BITS-1:0] pg_wa;
  logic [7:0]  pg_wd;
  logic        push_valid;
  logic [7:0]  push_data;
  logic        push_ready;
  logic        pop_valid;
  logic        pop_ready;
  logic [7:0]  pop_data;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // lock range decode: top quarter, top half or the whole array
  function automatic logic is_locked(input logic [`EWD_ADDR_MSB:0] a,
                                     input logic [1:0] code);
    logic hit;
    hit = 1'b1;
    if (code == `EWD_BL_NONE) begin
      hit = 1'b0;
    end else if (code == `EWD_BL_QUARTER) begin
      hit = a[`EWD_ADDR_MSB] & a[`EWD_ADDR_MSB-1];
    end else if (code == `EWD_BL_HALF) begin
      hit = a[`EWD_ADDR_MSB];
    end
    return hit;
  endfunction

  // watchdog period select; the off code never reaches this
  function automatic logic [31:0] wdt_limit(input logic [1:0] code);
    logic [31:0] lim;
    lim = WDT_P2_CYC;
    if (code == `EWD_WD_P0) begin
      lim = WDT_P0_CYC;
    end else if (code == `EWD_WD_P1) begin
      lim = WDT_P1_CYC;
    end
    return lim;
  endfunction

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    next_s     = s;
    mem_we     = 1'b0;
    mem_wa     = '0;
    mem_wd     = '0;
    pg_we      = 1'b0;
    pg_wa      = '0;
    pg_wd      = '0;
    push_valid = 1'b0;
    push_data  = '0;
    // pins pass two flops before anything looks at them
    next_s.cs_s1  = cs_n_i;
    next_s.cs_s2  = s.cs_s1;
    next_s.cs_d   = s.cs_s2;
    next_s.sck_s1 = sck_i;
    next_s.sck_s2 = s.sck_s1;
    next_s.sck_d  = s.sck_s2;
    next_s.si_s1  = si_i;
    next_s.si_s2  = s.si_s1;
    next_s.wp_s1  = wp_n_i;
    next_s.wp_s2  = s.wp_s1;
    cs_fall   = s.cs_d & ~s.cs_s2;
    cs_rise   = ~s.cs_d & s.cs_s2;
    sck_rise  = ~s.sck_d & s.sck_s2;
    sck_fall  = s.sck_d & ~s.sck_s2;
    busy      = (s.cst != ewd_pkg::C_IDLE);
    sr_prot   = s.ppen & ~s.wp_s2;
    shifted   = {s.shreg[6:0], s.si_s2};
    byte_end  = (s.bitcnt == `EWD_BYTE_LAST);
    full_addr = {s.addr[15:8], shifted};
    status    = {s.ppen, s.flag, s.wd, s.bl, s.write_enable_latch, busy}; // RULE21 RULE14
    prog_addr = {s.pg_base, s.prog_idx};
    pop_ready = (s.cst != ewd_pkg::C_PROG);

    // write-cycle sequencer: wait for the fifo to drain, program, then time out
    case (s.cst)
      ewd_pkg::C_DRAIN: begin
        if (!pop_valid) begin
          next_s.cst      = ewd_pkg::C_PROG;
          next_s.prog_idx = '0;
        end
      end
      ewd_pkg::C_PROG: begin
        if (s.pg_mask[s.prog_idx] && !is_locked(prog_addr, s.bl)) begin // RULE11 RULE23
          mem_we = 1'b1;
          mem_wa = prog_addr;
          mem_wd = page_buf[s.prog_idx];
        end
        next_s.prog_idx = s.prog_idx + `EWD_PAGE_BITS'(1);
        if (s.prog_idx == `EWD_PAGE_LAST) begin
          next_s.cst     = ewd_pkg::C_WAIT;
          next_s.timer   = '0;
          next_s.pg_mask = '0;
        end
      end
      ewd_pkg::C_WAIT: begin
        next_s.timer = s.timer + 32'h1;
        if (s.timer >= WR_CYCLE_CYC - 32'h1) begin
          next_s.cst = ewd_pkg::C_IDLE; // RULE24
          next_s.write_enable_latch = 1'b0; // RULE24
        end
      end
      default: begin
      end
    endcase

    // page loader: each popped byte lands at the running page offset
    if (pop_valid && pop_ready) begin
      pg_we  = 1'b1;
      pg_wa  = s.pg_ofs;
      pg_wd  = pop_data;
      next_s.pg_mask[s.pg_ofs] = 1'b1;
      next_s.pg_ofs = s.pg_ofs + `EWD_PAGE_BITS'(1); // RULE10
    end

    // link: frames open only on a select fall, so nothing runs before one
    if (cs_fall) begin
      next_s.link   = ewd_pkg::L_OPC; // RULE18
      next_s.bitcnt = '0;
      next_s.so_oe  = 1'b0;
    end else if (cs_rise) begin
      next_s.link  = ewd_pkg::L_IDLE;
      next_s.so_oe = 1'b0; // RULE5
      case (s.link)
        ewd_pkg::L_CMDEND: begin
          if (s.opcode == `EWD_OP_SET_WRITE_LATCH_CMD_LATCH) begin
            next_s.write_enable_latch = 1'b1; // RULE7
          end else if (s.opcode == `EWD_OP_CLEAR) begin
            next_s.write_enable_latch  = 1'b0;
            next_s.flag = 1'b0;
          end else if (s.opcode == `EWD_OP_FLAG_SET) begin
            next_s.flag = 1'b1;
          end else if (s.opcode == `EWD_OP_STAT_WR && s.write_enable_latch && !busy && !sr_prot) begin
            next_s.ppen  = s.sw_data[`EWD_SR_PPEN]; // RULE1 RULE11
            next_s.wd    = s.sw_data[`EWD_SR_WD_HI:`EWD_SR_WD_LO];
            next_s.bl    = s.sw_data[`EWD_SR_BL_HI:`EWD_SR_BL_LO];
            next_s.cst   = ewd_pkg::C_WAIT;
            next_s.timer = '0;
          end
        end
        ewd_pkg::L_RXD: begin
          // only a select rise right on a byte boundary commits the page
          if (s.bitcnt == '0 && s.got_byte && s.write_enable_latch && !busy) begin // RULE12 RULE11
            next_s.cst = ewd_pkg::C_DRAIN;
          end
        end
        default: begin
        end
      endcase
    end else if (s.link != ewd_pkg::L_IDLE && sck_rise) begin
      next_s.shreg  = shifted;
      next_s.bitcnt = s.bitcnt + 3'h1;
      case (s.link)
        ewd_pkg::L_OPC: begin
          if (byte_end) begin
            next_s.opcode = shifted;
            next_s.abyte  = 1'b0;
            if (shifted == `EWD_OP_READ || shifted == `EWD_OP_WRITE) begin // RULE20
              next_s.link = ewd_pkg::L_ADDR;
            end else if (shifted == `EWD_OP_STAT_RD) begin
              next_s.tx   = status; // RULE6
              next_s.link = ewd_pkg::L_TXD;
            end else if (shifted == `EWD_OP_STAT_WR) begin
              next_s.link = ewd_pkg::L_SDATA;
            end else if (shifted == `EWD_OP_SET_WRITE_LATCH_CMD_LATCH || shifted == `EWD_OP_CLEAR ||
                         shifted == `EWD_OP_FLAG_SET) begin
              next_s.link = ewd_pkg::L_CMDEND;
            end else begin
              next_s.link = ewd_pkg::L_SKIP;
            end
          end
        end
        ewd_pkg::L_ADDR: begin
          if (byte_end && !s.abyte) begin
            next_s.addr[15:8] = shifted;
            next_s.abyte      = 1'b1;
          end else if (byte_end && s.opcode == `EWD_OP_READ) begin
            // upper address bits beyond the array are ignored
            next_s.tx   = mem[full_addr[`EWD_ADDR_MSB:0]]; // RULE2
            next_s.addr = {3'h0, full_addr[`EWD_ADDR_MSB:0] + `EWD_ADDR_BITS'(1)}; // RULE3
            next_s.link = ewd_pkg::L_TXD;
          end else if (byte_end && busy) begin
            next_s.link = ewd_pkg::L_SKIP;
          end else if (byte_end) begin
            next_s.addr     = full_addr;
            next_s.pg_base  = full_addr[`EWD_ADDR_MSB:`EWD_PAGE_BITS];
            next_s.pg_ofs   = full_addr[`EWD_PAGE_BITS-1:0];
            next_s.pg_mask  = '0;
            next_s.got_byte = 1'b0;
            next_s.link     = ewd_pkg::L_RXD;
          end
        end
        ewd_pkg::L_TXD: begin
          if (byte_end && s.opcode == `EWD_OP_READ) begin
            next_s.tx   = mem[s.addr[`EWD_ADDR_MSB:0]]; // RULE3
            next_s.addr = {3'h0, s.addr[`EWD_ADDR_MSB:0] + `EWD_ADDR_BITS'(1)}; // RULE4
          end else if (byte_end) begin
            next_s.tx = status; // RULE14
          end
        end
        ewd_pkg::L_RXD: begin
          // a full fifo drops the byte; the drain outruns the link by far
          if (byte_end) begin
            push_valid      = 1'b1;
            push_data       = shifted;
            next_s.got_byte = 1'b1;
          end
        end
        ewd_pkg::L_SDATA: begin
          if (byte_end) begin
            next_s.sw_data = shifted;
            next_s.link    = ewd_pkg::L_CMDEND;
          end
        end
        ewd_pkg::L_CMDEND: begin
          next_s.link = ewd_pkg::L_SKIP; // RULE7
        end
        default: begin
        end
      endcase
    end else if (s.link == ewd_pkg::L_TXD && sck_fall) begin
      next_s.so    = s.tx[7];
      next_s.tx    = {s.tx[6:0], 1'b0};
      next_s.so_oe = 1'b1;
    end

    // power-up hold, then the watchdog with its reset pulse
    if (!s.por_done) begin
      next_s.por_cnt = s.por_cnt + 32'h1;
      if (s.por_cnt >= PWRUP_CYC - 32'h1) begin
        next_s.por_done = 1'b1; // RULE19
      end
    end else if (s.rst_cnt != '0) begin
      next_s.rst_cnt = s.rst_cnt - 32'h1;
    end else if (s.wd == `EWD_WD_OFF || cs_fall) begin
      next_s.wdt_cnt = '0; // RULE22
    end else begin
      next_s.wdt_cnt = s.wdt_cnt + 32'h1;
      if (s.wdt_cnt >= wdt_limit(s.wd) - 32'h1) begin
        next_s.rst_cnt = RST_PULSE_CYC; // RULE15 RULE22
        next_s.wdt_cnt = '0;
      end
    end
    rst_act = !next_s.por_done || (next_s.rst_cnt != '0);
    // open drain: active-high variant pulls low only while not in reset
    next_s.rst_oe = ACTIVE_HIGH_RESET ? !rst_act : rst_act; // RULE15 RULE16
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s <= RST_S; // RULE17
    end else begin
      s <= next_s;
    end
  end

  // array and page buffer stay out of reset, like real cells
  always_ff @(posedge sys_clk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (pg_we) begin
      page_buf[pg_wa] <= pg_wd;
    end
  end

  // ****************************************************************
  // write data fifo
  // ****************************************************************
  ewd_fifo #(
    .WIDTH (`EWD_FIFO_WIDTH),
    .DEPTH (`EWD_FIFO_DEPTH)
  ) u_wdata_fifo (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_data),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_data)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign so_o         = s.so;
  assign so_oe_o      = s.so_oe;
  assign wdt_rst_o    = 1'b0;   // only ever pulls low
  assign wdt_rst_oe_o = s.rst_oe;
  assign status_o     = {s.ppen, s.flag, s.wd, s.bl, s.write_enable_latch, s.cst != ewd_pkg::C_IDLE};

endmodule // ewd_spi_eeprom_wdt

/* File: ewd_props.sv */
// ewd_props.sv: port checker of the eeprom watchdog command logic
`timescale 1ns/100ps
module ewd_props (
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic       cs_n_i,
  input wire logic       sck_i,
  input wire logic       si_i,
  input wire logic       wp_n_i,
  input wire logic       so_o,
  input wire logic       so_oe_o,
  input wire logic       wdt_rst_o,
  input wire logic       wdt_rst_oe_o,
  input wire logic [7:0] status_o
);
  // ****************************************
  // port relations, low-active reset variant
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  rst_open_drain_a: assert property (wdt_rst_o == 1'b0)
    else $error("reset pin driven high");
  por_hold_a: assert property ($fell(reset_i) |-> wdt_rst_oe_o [*8])
    else $error("reset released too early after power-up");
  pulse_len_a: assert property ($rose(wdt_rst_oe_o) |-> wdt_rst_oe_o [*8])
    else $error("watchdog reset pulse too short");
  oe_idle_a: assert property (cs_n_i [*6] |-> !so_oe_o)
    else $error("serial output driven while deselected");
  oe_frame_a: assert property ($rose(so_oe_o) |-> $past(!cs_n_i, 3))
    else $error("serial output enabled outside a frame");
  busy_start_a: assert property ($rose(status_o[0]) |-> cs_n_i && $past(status_o[1]))
    else $error("write cycle started without latch or deselect");
  busy_hold_a: assert property ($rose(status_o[0]) |-> status_o[0] [*8])
    else $error("busy flag dropped early");
  wel_end_a: assert property ($fell(status_o[0]) |-> !status_o[1])
    else $error("latch kept after write cycle");
  wel_set_a: assert property ($rose(status_o[1]) |-> cs_n_i)
    else $error("latch set inside an open frame");
  // protect pin low with the enable bit set must freeze the nonvolatile bits
  lock_freeze_a: assert property (!wp_n_i && $past(!wp_n_i, 4) && $past(status_o[7])
    |-> $stable({status_o[7], status_o[5:2]})) else $error("protected status bits changed");
endmodule // ewd_props
bind ewd_spi_eeprom_wdt ewd_props u_props (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i), .wp_n_i(wp_n_i), .so_o(so_o),
  .so_oe_o(so_oe_o), .wdt_rst_o(wdt_rst_o), .wdt_rst_oe_o(wdt_rst_oe_o), .status_o(status_o));

/* File: ewd_host.sv */
// ewd_host.sv: behavioural spi host, mode 0, 400 ns serial clock
`timescale 1ns/100ps
module ewd_host (
  input  wire logic sys_clk_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  // ****************************************
  // frame and bit tasks
  // ****************************************
  // serial clock stands low between frames
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // a fresh select fall opens every frame
  task automatic open_f();
    wt(4);
    cs_n_o = 1'b0;
    wt(4);
  endtask
  // deselect four clocks after the last falling clock; input line toggled so it is never stale
  task automatic close_f();
    wt(4);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    wt(8);
  endtask
  // msb first, sampled just before each rise; undriven output reads unknown
  task automatic bits(input logic [31:0] d, input int n, output logic [31:0] r);
    r = '0;
    for (int i = n - 1; i >= 0; i--) begin
      si_o = d[i];
      wt(4);
      r = {r[30:0], so_oe_i ? so_i : 1'bx};
      sck_o = 1'b1;
      wt(4);
      sck_o = 1'b0;
    end
  endtask
endmodule // ewd_host

/* File: ewd_spi_eeprom_wdt_tb_top.sv */
// ewd_spi_eeprom_wdt_tb_top.sv: self-checking bench of the eeprom watchdog command logic
`timescale 1ns/100ps
module ewd_spi_eeprom_wdt_tb_top;
  localparam int LIM [4] = '{200, 150, 100, 300};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wp_n = 1'b1;
  logic        cs_n, sck, si, so, so_oe, rst_pin, rst_oe;
  logic [7:0]  status, v;
  logic [31:0] r;
  logic [7:0]  em [3];
  logic [15:0] pa [3] = '{16'h1800, 16'h1000, 16'h0000};
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  // ****************************************
  // design, host and clock
  // ****************************************
  ewd_spi_eeprom_wdt #(.WDT_P0_CYC(32'(LIM[0])), .WDT_P1_CYC(32'(LIM[1])),
    .WDT_P2_CYC(32'(LIM[2])), .PWRUP_CYC(32'd20), .RST_PULSE_CYC(32'd10),
    .WR_CYCLE_CYC(32'd200)) uut (.sys_clk_i(clk), .reset_i(rst), .cs_n_i(cs_n),
    .sck_i(sck), .si_i(si), .wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe),
    .wdt_rst_o(rst_pin), .wdt_rst_oe_o(rst_oe), .status_o(status));
  ewd_host h (.sys_clk_i(clk), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so),
    .so_oe_i(so_oe));
  always #25 clk = ~clk;
  // hang guard, ceiling well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt = error_cnt + 1;
      summarize();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tx(input logic [31:0] d, input int n);
    h.bits(d, n, r);
  endtask
  task automatic cmd(input logic [7:0] op);
    h.open_f();
    tx(32'(op), 8);
    h.close_f();
  endtask
  // bounded wait for the busy flag to drop
  task automatic wt_idle();
    h.wt(8);
    for (int i = 0; i < 600 && status[0] !== 1'b0; i++) h.wt(1);
  endtask
  task automatic sq(input logic [7:0] e);
    h.open_f();
    tx(32'h05, 8);
    tx(32'h0, 8);
    h.close_f();
    chk(r[7:0], e);
  endtask
  task automatic rq(input logic [15:0] a, input logic [15:0] e);
    h.open_f();
    tx({8'h03, a}, 24);
    tx(32'h0, 16);
    h.close_f();
    chk(r[15:8], e[15:8]);
    chk(r[7:0], e[7:0]);
  endtask
  // data bits 1 and 0 always sent as zero
  task automatic wsr(input logic [7:0] d);
    cmd(8'h06);
    h.open_f();
    tx({8'h01, d[7:2], 2'h0}, 16);
    h.close_f();
    wt_idle();
  endtask
  // mode 1 skips the latch, 2 adds a partial byte, 3 reads status while busy
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input int n, input int m);
    if (m != 1) cmd(8'h06);
    h.open_f();
    tx({8'h02, a}, 24);
    for (int i = 0; i < n; i++) tx(32'(d + 8'(i)), 8);
    if (m == 2) tx(32'h5, 3);
    h.close_f();
    if (m == 3) sq(8'h03);
    wt_idle();
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    h.wt(1);
    chk(status, 8'h00);
    chk({so_oe, rst_pin, rst_oe}, 8'h01);
    h.wt(30);
    chk({7'h0, rst_oe}, 8'h00);
    sq(8'h00);
    $display("test reset done");
    cmd(8'h06);
    sq(8'h02);
    cmd(8'h00);
    sq(8'h42);
    cmd(8'h04);
    sq(8'h00);
    h.open_f();
    tx(32'h00c, 9);
    h.close_f();
    sq(8'h00);
    $display("test latch done");
    wr(16'h0010, 8'ha5, 2, 3);
    sq(8'h00);
    rq(16'h0010, 16'ha5a6);
    wr(16'h1fff, 8'h5a, 1, 0);
    wr(16'h0000, 8'hc3, 1, 0);
    rq(16'h1fff, 16'h5ac3);
    wr(16'h003e, 8'h11, 4, 0);
    rq(16'h003e, 16'h1112);
    rq(16'h0020, 16'h1314);
    wr(16'h0010, 8'h66, 1, 1);
    rq(16'h0010, 16'ha5a6);
    wr(16'h0010, 8'h77, 1, 2);
    rq(16'h0010, 16'ha5a6);
    cmd(8'h04);
    $display("test array done");
    // lock code c guards the first c probes, top quarter first
    for (int c = 0; c < 4; c++) begin
      wsr({4'h0, 2'(c), 2'h0});
      sq({4'h0, 2'(c), 2'h0});
      for (int k = 0; k < 3; k++) begin
        v = 8'h40 + 8'(c * 3 + k);
        wr(pa[k], v, 2, 0);
        if (k >= c) em[k] = v;
        rq(pa[k], {em[k], em[k] + 8'h1});
      end
    end
    $display("test lock done");
    wsr(8'h84);
    wp_n = 1'b0;
    wsr(8'h00);
    cmd(8'h04);
    sq(8'h84);
    wp_n = 1'b1;
    wsr(8'h00);
    sq(8'h00);
    $display("test pin done");
    // each period code timed from a fresh select fall
    for (int c = 0; c < 4; c++) begin
      wsr({2'h0, 2'(c), 4'h0});
      h.open_f();
      h.close_f();
      h.wt(LIM[c] - 20);
      chk({7'h0, rst_oe}, 8'h00);
      for (int i = 0; i < 40 && rst_oe !== 1'b1; i++) h.wt(1);
      chk({7'h0, rst_oe}, {7'h0, c != 3});
    end
    $display("test watchdog done");
    summarize();
  end
endmodule // ewd_spi_eeprom_wdt_tb_top
